//--- verilog/cfg_loader_params.svh
// offsets, field positions, reset values and timing counts of the loader
`ifndef CFG_LOADER_PARAMS_SVH
`define CFG_LOADER_PARAMS_SVH

`define CFG_RESET_VAL 8'h00
`define CFG_UVDIS_BIT 7
`define CFG_UVSEL_HI 6
`define CFG_UVSEL_LO 5
`define CFG_OSC_HI 2
`define CFG_OSC_LO 0

`define REG_STATUS_OFS 8'h00
`define REG_CTRL_OFS 8'h04
`define REG_TIMER_OFS 8'h08
`define CTRL_RESTART_BIT 0

`define CLK_SYS_MHZ 200
`define OSC8M_PERIOD_NS 125
`define OSC4M_PERIOD_NS 250
`define OSC2M_PERIOD_NS 500
`define OSC1M_PERIOD_NS 1000
`define PRESCALE_DIV 1024
`define HALF_COUNT 128

`endif

//--- verilog/cfg_loader_pkg.sv
// types shared by the configuration loader files
package cfg_loader_pkg;

  typedef enum logic [2:0]
  {
    OSC_EXT_RC = 3'h0,
    OSC_INT_4M = 3'h1,
    OSC_INT_2M = 3'h2,
    OSC_INT_1M = 3'h3,
    OSC_INT_8M = 3'h4,
    OSC_ALIAS_4M = 3'h5,
    OSC_ALIAS_2M = 3'h6,
    OSC_XTAL = 3'h7
  } osc_src_type;

  typedef enum logic [3:0]
  {
    ST_FIRST_HALF = 4'h1,
    ST_APPLY = 4'h2,
    ST_SECOND_HALF = 4'h4,
    ST_RUN = 4'h8
  } state_type;

  typedef struct packed
  {
    logic undervoltageResetDisable;
    logic [1:0] undervoltageThresholdSelect;
    osc_src_type oscSelect;
  } cfg_type;

endpackage

//--- verilog/sync_stage.sv
// two flip-flop synchroniser for pins and other foreign levels
`timescale 1ns/100ps
module sync_stage #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      synced <= '0;
    end
    else
    begin
      meta_r <= async;
      synced <= meta_r;
    end
  end

endmodule

//--- verilog/interval_timer.sv
// prescaled interval timer counting one half of the stabilisation time
`timescale 1ns/100ps
module interval_timer #(
  parameter int PRESC_DIV = 1024,
  parameter int HALF_CNT = 128
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic tick,
  output logic done,
  output logic [7:0] count
);

  localparam int PW = $clog2(PRESC_DIV);
  localparam logic [PW-1:0] PRESC_LAST = PW'(PRESC_DIV - 1);
  localparam logic [7:0] CNT_LAST = 8'(HALF_CNT);

  logic [PW-1:0] presc_r;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || clear)
      presc_r <= '0;
    else if (tick && !done)
      presc_r <= (presc_r == PRESC_LAST) ? '0 : presc_r + 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || clear)
    begin
      count <= 8'h00;
      done <= 1'b0;
    end
    else if (tick && !done && presc_r == PRESC_LAST)
    begin
      count <= count + 8'h01;
      done <= (count + 8'h01) == CNT_LAST;
    end
  end

endmodule

//--- verilog/config_byte_loader_clock_select.sv
// power-up configuration byte loader with clock source switch
// Overview of operation
// - byte defaults 00H: undervoltage reset on, external RC source
// - bits 6:5 pick threshold 2.4V, 2.7V, 3.0V or 4.0V
// - bits 2:0 pick external RC, internal 4/2/1/8 MHz or crystal
// - code 101 acts as 4MHz internal, 110 as 2MHz internal
// - crystal source claims port3 pins 3 and 4 as oscillator pins
// - external RC claims port3 pin 4 as oscillator input only
// - byte applied about 32 ms after power-on, never earlier
// - first half is 128 timer counts of 4MHz divided by 1024
// - after loading, clock switches and second half runs on it
// - second half is 128 counts of selected clock divided by 1024
// - byte sampled only during stabilisation; new byte needs a reset
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/100ps
`include "cfg_loader_params.svh"
module config_byte_loader_clock_select #(
  parameter int PRESC_DIV = `PRESCALE_DIV,
  parameter int HALF_CNT = `HALF_COUNT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] cfgByteIn,
  input wire logic port3Pin3In,
  input wire logic port3Pin4In,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output cfg_loader_pkg::osc_src_type sysClkSel,
  output logic undervoltageResetEn,
  output logic [1:0] undervoltageThresholdSelect,
  output logic port3Pin5IsReset,
  output logic port3Pin3OscIn,
  output logic port3Pin4OscOut,
  output logic port3Pin4OscIn,
  output logic cpuHold,
  output logic cfgLoaded
);

  localparam logic [7:0] DIV_8M =
    8'(`OSC8M_PERIOD_NS * `CLK_SYS_MHZ / 1000 - 1);
  localparam logic [7:0] DIV_4M =
    8'(`OSC4M_PERIOD_NS * `CLK_SYS_MHZ / 1000 - 1);
  localparam logic [7:0] DIV_2M =
    8'(`OSC2M_PERIOD_NS * `CLK_SYS_MHZ / 1000 - 1);
  localparam logic [7:0] DIV_1M =
    8'(`OSC1M_PERIOD_NS * `CLK_SYS_MHZ / 1000 - 1);
  localparam logic [7:0] CFG_DEFAULT = `CFG_RESET_VAL;

  cfg_loader_pkg::state_type state_r;
  cfg_loader_pkg::cfg_type cfg_r;
  cfg_loader_pkg::cfg_type cfgSampled;
  cfg_loader_pkg::osc_src_type activeSrc;
  logic [7:0] cfgSync;
  logic [1:0] pinSync;
  logic oscLevel;
  logic oscPrev_r;
  logic oscRise;
  logic [7:0] divCnt_r;
  logic [7:0] divLast;
  logic extSrc;
  logic tick;
  logic timerClear;
  logic timerDone;
  logic [7:0] timerCount;
  logic restart_r;
  logic wrPend_r;
  logic [7:0] wrAddr_r;
  logic [31:0] statusWord;
  logic [31:0] readMux;
  logic addrAccept;

  // collapse the two unlisted codes onto their documented twins
  function automatic cfg_loader_pkg::osc_src_type
    aliasOsc(input logic [2:0] code);
    case (code)
      3'h5: aliasOsc = cfg_loader_pkg::OSC_INT_4M;
      3'h6: aliasOsc = cfg_loader_pkg::OSC_INT_2M;
      default: aliasOsc = cfg_loader_pkg::osc_src_type'(code);
    endcase
  endfunction

  // the byte comes from non-volatile storage, so treat it as foreign
  sync_stage #(.WIDTH(8)) cfgSyncInst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async(cfgByteIn),
    .synced(cfgSync)
  );

  sync_stage #(.WIDTH(2)) pinSyncInst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async({port3Pin4In, port3Pin3In}),
    .synced(pinSync)
  );

  // bits 4:3 are simply not picked up
  always_comb
  begin
    cfgSampled.undervoltageResetDisable = cfgSync[`CFG_UVDIS_BIT];
    cfgSampled.undervoltageThresholdSelect =
      cfgSync[`CFG_UVSEL_HI:`CFG_UVSEL_LO];
    cfgSampled.oscSelect =
      aliasOsc(cfgSync[`CFG_OSC_HI:`CFG_OSC_LO]);
  end

  // first half always runs on the internal 4MHz source
  always_comb
  begin
    if (state_r == cfg_loader_pkg::ST_FIRST_HALF)
      activeSrc = cfg_loader_pkg::OSC_INT_4M;
    else
      activeSrc = cfg_r.oscSelect;
  end

  always_comb
  begin
    extSrc = 1'b0;
    case (activeSrc)
      cfg_loader_pkg::OSC_INT_8M: divLast = DIV_8M;
      cfg_loader_pkg::OSC_INT_4M: divLast = DIV_4M;
      cfg_loader_pkg::OSC_INT_2M: divLast = DIV_2M;
      cfg_loader_pkg::OSC_INT_1M: divLast = DIV_1M;
      default:
      begin
        divLast = DIV_4M;
        extSrc = 1'b1;
      end
    endcase
  end

  // crystal arrives on pin 3, external RC on pin 4
  assign oscLevel = (cfg_r.oscSelect == cfg_loader_pkg::OSC_XTAL) ?
    pinSync[0] : pinSync[1];
  assign oscRise = oscLevel && !oscPrev_r;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      oscPrev_r <= 1'b0;
    else
      oscPrev_r <= oscLevel;
  end

  // internal sources are modelled by dividing the system clock
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || restart_r || timerClear)
      divCnt_r <= 8'h00;
    else if (divCnt_r >= divLast)
      divCnt_r <= 8'h00;
    else
      divCnt_r <= divCnt_r + 8'h01;
  end

  assign tick = extSrc ? oscRise : (divCnt_r == divLast);
  assign timerClear = (state_r == cfg_loader_pkg::ST_APPLY);

  interval_timer #(
    .PRESC_DIV(PRESC_DIV),
    .HALF_CNT(HALF_CNT)
  ) timerInst (
    .clk_sys(clk_sys),
    .rst_n(rst_n && !restart_r),
    .clear(timerClear),
    .tick(tick),
    .done(timerDone),
    .count(timerCount)
  );

  // sequence: first half, apply, second half, run
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || restart_r)
      state_r <= cfg_loader_pkg::ST_FIRST_HALF;
    else
    begin
      case (state_r)
        cfg_loader_pkg::ST_FIRST_HALF:
          if (timerDone)
            state_r <= cfg_loader_pkg::ST_APPLY;
        cfg_loader_pkg::ST_APPLY:
          state_r <= cfg_loader_pkg::ST_SECOND_HALF;
        cfg_loader_pkg::ST_SECOND_HALF:
          if (timerDone)
            state_r <= cfg_loader_pkg::ST_RUN;
        cfg_loader_pkg::ST_RUN:
          state_r <= cfg_loader_pkg::ST_RUN;
        default:
          state_r <= cfg_loader_pkg::ST_FIRST_HALF;
      endcase
    end
  end

  // the byte is captured once per reset, never while running
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || restart_r)
    begin
      cfg_r <= cfg_loader_pkg::cfg_type'({CFG_DEFAULT[7:5],
        CFG_DEFAULT[2:0]});
      cfgLoaded <= 1'b0;
    end
    else if (state_r == cfg_loader_pkg::ST_FIRST_HALF && timerDone)
    begin
      cfg_r <= cfgSampled;
      cfgLoaded <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sysClkSel <= cfg_loader_pkg::OSC_INT_4M;
      cpuHold <= 1'b1;
    end
    else
    begin
      sysClkSel <= activeSrc;
      cpuHold <= (state_r != cfg_loader_pkg::ST_RUN) || restart_r;
    end
  end

  // bit 7 set disables the undervoltage reset and makes port3 pin 5 the reset pin
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      undervoltageResetEn <= 1'b1;
      undervoltageThresholdSelect <= 2'h0;
      port3Pin5IsReset <= 1'b0;
    end
    else
    begin
      undervoltageResetEn <= !cfg_r.undervoltageResetDisable;
      undervoltageThresholdSelect <=
        cfg_r.undervoltageThresholdSelect;
      port3Pin5IsReset <= cfg_r.undervoltageResetDisable;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      port3Pin3OscIn <= 1'b0;
      port3Pin4OscOut <= 1'b0;
      port3Pin4OscIn <= 1'b0;
    end
    else
    begin
      port3Pin3OscIn <=
        cfg_r.oscSelect == cfg_loader_pkg::OSC_XTAL;
      port3Pin4OscOut <=
        cfg_r.oscSelect == cfg_loader_pkg::OSC_XTAL;
      port3Pin4OscIn <=
        cfg_r.oscSelect == cfg_loader_pkg::OSC_EXT_RC;
    end
  end

  // zero-wait slave: read data is prepared in the address phase
  assign addrAccept = hsel && hready && htrans[1];

  assign statusWord = {18'h0_0000, cfgLoaded, cpuHold, state_r,
    cfg_r.undervoltageResetDisable, cfg_r.undervoltageThresholdSelect,
    2'h0, cfg_r.oscSelect};

  always_comb
  begin
    case (haddr[7:0])
      `REG_STATUS_OFS: readMux = statusWord;
      `REG_TIMER_OFS: readMux = {24'h00_0000, timerCount};
      default: readMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      wrPend_r <= addrAccept && hwrite;
      if (addrAccept)
        wrAddr_r <= haddr[7:0];
      hrdata <= (addrAccept && !hwrite) ? readMux : 32'h0000_0000;
    end
  end

  // a restart is a full reset of the sequence, so the byte is reread
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      restart_r <= 1'b0;
    else
      restart_r <= wrPend_r && wrAddr_r == `REG_CTRL_OFS &&
        hwdata[`CTRL_RESTART_BIT];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

endmodule

//--- bench/config_byte_loader_clock_select_asserts.sv
// port-level checker of the configuration byte loader
`timescale 1ns/100ps
module config_byte_loader_clock_select_asserts #(
  parameter int PRESC_DIV = 1024,
  parameter int HALF_CNT = 128
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire cfg_loader_pkg::osc_src_type sysClkSel,
  input wire logic undervoltageResetEn,
  input wire logic [1:0] undervoltageThresholdSelect,
  input wire logic port3Pin5IsReset,
  input wire logic port3Pin3OscIn,
  input wire logic port3Pin4OscOut,
  input wire logic port3Pin4OscIn,
  input wire logic cpuHold,
  input wire logic cfgLoaded
);
  // one prescaler tick of slack for the phase of the first tick
  localparam int MIN_LOAD = PRESC_DIV * HALF_CNT * 50 - 60;
  int seqCnt;

  // a restart drops cfgLoaded, so the sequence count restarts there too
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || $fell(cfgLoaded))
    begin
      seqCnt <= 0;
    end
    else
    begin
      seqCnt <= seqCnt + 1;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_uv_polarity: assert property (
    undervoltageResetEn == !port3Pin5IsReset)
    else $error("undervoltage enable not inverse of pin5 reset use");
  a_no_alias: assert property (
    sysClkSel != cfg_loader_pkg::OSC_ALIAS_4M &&
    sysClkSel != cfg_loader_pkg::OSC_ALIAS_2M)
    else $error("alias code shown as active source");
  a_first_on_4m: assert property (
    $rose(cfgLoaded) |-> $past(sysClkSel) == cfg_loader_pkg::OSC_INT_4M)
    else $error("first half not run on internal 4MHz");
  a_load_not_early: assert property (
    $rose(cfgLoaded) |-> seqCnt >= MIN_LOAD)
    else $error("byte loaded before first half ended");
  a_hold_until_load: assert property (
    !cfgLoaded |-> cpuHold)
    else $error("execution released before byte loaded");
  a_xtal_pins: assert property (
    !cpuHold |-> port3Pin3OscIn == (sysClkSel == cfg_loader_pkg::OSC_XTAL)
    && port3Pin4OscOut == port3Pin3OscIn)
    else $error("crystal pin claim wrong");
  a_rc_pin: assert property (
    !cpuHold |-> port3Pin4OscIn == (sysClkSel == cfg_loader_pkg::OSC_EXT_RC))
    else $error("external RC pin claim wrong");
  a_run_frozen: assert property (
    !cpuHold [*2] |-> $stable(sysClkSel) &&
    $stable(undervoltageThresholdSelect))
    else $error("configuration changed while running");
  a_read_idle: assert property (
    !(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h0000_0000)
    else $error("read data outside a read data phase");
  a_bus_okay: assert property (
    hsel && htrans[1] && hready |=> hreadyout && !hresp)
    else $error("bus transfer not answered at once with okay");

  c_loaded: cover property ($rose(cfgLoaded));
  c_released: cover property ($fell(cpuHold));
  c_xtal_run: cover property (
    !cpuHold && sysClkSel == cfg_loader_pkg::OSC_XTAL);
endmodule

bind config_byte_loader_clock_select config_byte_loader_clock_select_asserts #(
  .PRESC_DIV(PRESC_DIV), .HALF_CNT(HALF_CNT)) i_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .sysClkSel(sysClkSel),
  .undervoltageResetEn(undervoltageResetEn),
  .undervoltageThresholdSelect(undervoltageThresholdSelect),
  .port3Pin5IsReset(port3Pin5IsReset), .port3Pin3OscIn(port3Pin3OscIn),
  .port3Pin4OscOut(port3Pin4OscOut), .port3Pin4OscIn(port3Pin4OscIn),
  .cpuHold(cpuHold), .cfgLoaded(cfgLoaded));

//--- bench/tb.sv
// self-checking testbench of the configuration byte loader
`timescale 1ns/100ps
module tb;
  localparam int PD = 4;
  localparam int HC = 3;
  logic clk_sys, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans, thr;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0] cfgByteIn;
  logic [3:0] pinDiv;
  logic uvEn, pin5Rst, p3In, p4Out, p4In, cpuHold, cfgLoaded;
  cfg_loader_pkg::osc_src_type sysClkSel;
  int badCount, cmpCount;

  assign hready = hreadyout;
  config_byte_loader_clock_select #(.PRESC_DIV(PD), .HALF_CNT(HC)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .cfgByteIn(cfgByteIn),
    .port3Pin3In(pinDiv[3]), .port3Pin4In(pinDiv[3]), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sysClkSel(sysClkSel), .undervoltageResetEn(uvEn),
    .undervoltageThresholdSelect(thr), .port3Pin5IsReset(pin5Rst),
    .port3Pin3OscIn(p3In), .port3Pin4OscOut(p4Out),
    .port3Pin4OscIn(p4In), .cpuHold(cpuHold), .cfgLoaded(cfgLoaded));

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // external oscillator pins: a rising edge every 16 cycles
  always @(posedge clk_sys) pinDiv <= pinDiv + 4'h1;

  task automatic tallyAndFinish();
    $display("compares %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    cmpCount++;
    if (g !== e)
    begin
      badCount++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic waitSig(input logic sel, output int n);
    n = 0;
    while ((sel ? cpuHold !== 1'b0 : cfgLoaded !== 1'b1) && n < 5000)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 5000)
    begin
      badCount++;
      $display("mismatch waitSig exp done got timeout");
      tallyAndFinish();
    end
  endtask

  // value before the next rising edge is what that edge samples
  task automatic waitReady();
    int n;
    n = 0;
    @(negedge clk_sys);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 50)
    begin
      badCount++;
      $display("mismatch hreadyout exp 1 got timeout");
      tallyAndFinish();
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, wd,
    output logic [31:0] rd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    waitReady();
    @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    waitReady();
    rd = hrdata;
  endtask

  task automatic testDefaults();
    logic [31:0] rd;
    chk("defaults", 32'h0000_0291, 32'({cpuHold, cfgLoaded, uvEn, thr,
      p4In, 1'b0, sysClkSel}));
    bus(1'b0, 32'h4, 32'h0, rd);
    chk("ctrlRead", 32'h0, rd);
    bus(1'b0, 32'h10, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    $display("test defaults done");
  endtask

  task automatic testBoot(input logic [2:0] c);
    logic [7:0] b;
    logic [2:0] ec;
    logic [31:0] rd;
    int n1, n2, tk;
    b = {c[0], c[1:0], 2'b11, c};
    ec = (c == 3'h5) ? 3'h1 : (c == 3'h6) ? 3'h2 : c;
    tk = (c == 3'h0 || c == 3'h7) ? 16 : (ec == 3'h1) ? 50 :
      (ec == 3'h2) ? 100 : (ec == 3'h3) ? 200 : 25;
    @(posedge clk_sys);
    cfgByteIn <= b;
    bus(1'b1, 32'h4, 32'h1, rd);
    repeat (3) @(negedge clk_sys);
    chk("holdStart", 32'h9, 32'({cfgLoaded, cpuHold, sysClkSel}));
    waitSig(1'b0, n1);
    chk("firstHalf", 1, 32'(n1 > PD*HC*50-60 && n1 < PD*HC*50+10));
    waitSig(1'b1, n2);
    chk("secondHalf", 1, 32'(n2 >= PD*HC*tk-tk && n2 <= PD*HC*tk+tk+10));
    chk("clkSel", 32'(ec), 32'(sysClkSel));
    chk("uvOut", 32'({c[0], c[1:0], !c[0]}), 32'({pin5Rst, thr, uvEn}));
    chk("pins", 32'({c == 3'h7, c == 3'h7, c == 3'h0}),
      32'({p3In, p4Out, p4In}));
    bus(1'b0, 32'h0, 32'h0, rd);
    chk("status", 32'({6'h28, c[0], c[1:0], 2'b00, ec}), 32'(rd[13:0]));
    bus(1'b0, 32'h8, 32'h0, rd);
    chk("timer", 32'(HC), rd);
    @(posedge clk_sys);
    cfgByteIn <= ~b;
    repeat (20) @(negedge clk_sys);
    chk("noResample", 32'({ec, c[1:0]}), 32'({sysClkSel, thr}));
    $display("test boot %0d done", c);
  endtask

  initial
  begin
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    cfgByteIn = 8'h00;
    pinDiv = 4'h0;
    badCount = 0;
    cmpCount = 0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(negedge clk_sys);
    testDefaults();
    for (int c = 0; c < 8; c++)
      testBoot(3'(c));
    tallyAndFinish();
  end
endmodule
